// >>> mc_pkg.sv
// Constants, register map and types for one programmable logic cell.
// Assumes a single 100 MHz clock and an AXI4-Lite master for configuration.
package mc_pkg;
   localparam int N_CELLS = 32;
   localparam int N_DED = 4;
   localparam int N_IO = 32;
   localparam int N_PINS = N_DED + N_IO;
   localparam int GBUS_W = N_PINS + N_CELLS;
   localparam int N_REGION = 4;
   localparam int LIT_W = GBUS_W + N_REGION;
   localparam int N_PT = 5;
   localparam int MATRIX_MAX = 40;
   localparam int CASC_MAX_PT = 40;
   localparam logic [3:0] CASC_MAX_CELLS = 4'(CASC_MAX_PT / N_PT);
   // Register byte offsets
   localparam logic [7:0] OFS_CFG0 = 8'h00;
   localparam logic [7:0] OFS_CFG1 = 8'h04;
   localparam logic [7:0] OFS_MATRIX = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h14;
   localparam logic [7:0] OFS_SIGNATURE = 8'h18;
   localparam logic [7:0] OFS_FUSE = 8'h1C;
   localparam logic [7:0] OFS_TERM = 8'h40;
   localparam logic [7:0] TERM_STRIDE = 8'h20;
   localparam logic [31:0] MATRIX_TOP_MASK = 32'h0000_000F;
   localparam logic [31:0] LIT_TOP_MASK = 32'h0000_00FF;
   // Reset values
   localparam logic [31:0] CFG0_RST = 32'h0000_001F;
   localparam logic [31:0] CFG1_RST = 32'h0000_0000;
   localparam logic [15:0] SIGNATURE_RST = 16'h0000;
   // Responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // Status field positions
   localparam int ST_FF = 0;
   localparam int ST_SUM = 1;
   localparam int ST_COMB = 2;
   localparam int ST_PIN = 3;
   localparam int ST_CASC_OVF = 4;
   localparam int ST_FUSE = 5;
   localparam int ST_PT = 8;
   localparam int ST_MCOUNT = 16;

   typedef enum logic [2:0] {MODE_D = 3'h0, MODE_T = 3'h1, MODE_JK = 3'h2, MODE_SR = 3'h3,
      MODE_LATCH = 3'h4} mc_ff_mode_t;
   typedef enum logic [1:0] {XOR_LOW = 2'h0, XOR_HIGH = 2'h1, XOR_PT = 2'h2} mc_xor_src_t;
   typedef enum logic [1:0] {D_XOR = 2'h0, D_PT = 2'h1, D_PIN = 2'h2} mc_d_src_t;
   typedef enum logic [1:0] {CLR_GLOBAL = 2'h0, CLR_PT = 2'h1, CLR_BOTH = 2'h2,
      CLR_OFF = 2'h3} mc_clr_src_t;
   typedef enum logic [1:0] {IO_IN = 2'h0, IO_OUT = 2'h1, IO_BIDIR = 2'h2} mc_io_mode_t;
   typedef enum logic [2:0] {OE_PIN0 = 3'h0, OE_PIN0_N = 3'h1, OE_PIN1 = 3'h2, OE_PIN1_N = 3'h3,
      OE_IO = 3'h4, OE_CELL = 3'h5} mc_oe_src_t;
   typedef enum logic [2:0] {SEL_NONE = 3'h0, SEL_CFG0 = 3'h1, SEL_CFG1 = 3'h2, SEL_MATRIX = 3'h3,
      SEL_STATUS = 3'h4, SEL_SIG = 3'h5, SEL_FUSE = 3'h6, SEL_TERM = 3'h7} mc_sel_t;

   typedef struct packed {
      logic [2:0] pad;
      logic cascade_en;
      logic keeper;
      mc_io_mode_t io_mode;
      logic [1:0] oe_idx;
      mc_oe_src_t oe_src;
      logic fb_reg;
      logic out_reg;
      logic set_en;
      mc_clr_src_t clr_src;
      logic ce_en;
      logic [1:0] clk_sel;
      mc_ff_mode_t ff_mode;
      mc_d_src_t d_src;
      mc_xor_src_t xor_src;
      logic [4:0] to_sum;
   } mc_cfg0_t;

   typedef struct packed {
      logic [7:0] pad;
      logic [2:0] fold_pt;
      logic [2:0] k_pt;
      logic [2:0] set_pt;
      logic [2:0] clr_pt;
      logic [2:0] ce_pt;
      logic [2:0] clk_pt;
      logic [2:0] d_pt;
      logic [2:0] xor_pt;
   } mc_cfg1_t;

   typedef struct packed {
      logic [2:0] global_clock_pins;
      logic global_clear_line;
      logic [1:0] oe_pin;
      logic [N_DED-1:0] ded;
      logic [N_IO-1:0] io;
      logic [N_DED-1:0] ded_drv;
      logic [N_IO-1:0] io_drv;
   } mc_pins_t;
endpackage

// >>> mc_cell.sv
// One programmable logic cell with its switch matrix, term array and storage element.
// Assumes pins are asynchronous, neighbour cells share aclk, and AXI4-Lite configures it.
// How it works
// RL1: five AND terms over global and regional literals
// RL2: each term goes to sum or control
// RL3: cascade chain reaches at most forty terms
// RL4: XOR second input: term, high or low
// RL5: data from XOR, term or pin
// RL6: storage acts as D, T, JK, SR
// RL7: latch passes while clock high, holds low
// RL8: clock from three global pins or term
// RL9: flip-flop updates on selected clock rising
// RL10: term-low clock enable ignores global clock edges
// RL11: clear from global, term, both, off
// RL12: set from term or off
// RL13: output and feedback independently registered or combinational
// RL14: enable from two pins, I/O or cells
// RL15: I/O input, output or bidirectional modes
// RL16: global bus, matrix picks at most forty
// RL17: inverted term drives four-cell regional bus
// RL18: regional terms reach nine-term sums
// RL19: keeper holds last level of released pin
// RL20: sixteen-bit user signature readable
// RL21: fuse hides configuration, signature stays readable
// RL22: clear beats set when both active
//
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module mc_cell
   import mc_pkg::*;
#(
   parameter int CELL_IDX = 0
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Device pins, asynchronous
   input wire mc_pins_t pins,
   // Own I/O pin drive
   output logic io_out,
   output logic io_oe_n,
   // Neighbour cells, same clock
   input wire logic [N_CELLS-1:0] feedback_in,
   output logic feedback_out,
   input wire logic [N_REGION-2:0] fold_in,
   output logic fold_out,
   input wire logic [N_REGION-1:0] oe_cell_in,
   input wire logic cascade_in,
   input wire logic [3:0] cascade_cells_in,
   output logic cascade_out,
   output logic [3:0] cascade_cells_out
);
   if (CELL_IDX < 0 || CELL_IDX >= N_CELLS) begin : g_chk
      $error("CELL_IDX out of range");
   end

   typedef struct packed {
      logic aw_have;
      logic [7:0] awaddr;
      logic w_have;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      mc_cfg0_t cfg0;
      mc_cfg1_t cfg1;
      logic [2:0][31:0] matrix;
      logic [N_PT-1:0][5:0][31:0] term;
      logic [15:0] signature;
      logic fuse;
      mc_pins_t sync1;
      mc_pins_t sync2;
      logic [N_PINS-1:0] keep;
      logic clk_prev;
      logic ff_q;
      logic io_out;
      logic io_oe_n;
      logic fb_out;
      logic fold_out;
      logic casc_out;
      logic [3:0] casc_cells;
   } mc_state_t;

   mc_state_t s;
   mc_state_t n;

   function automatic mc_sel_t reg_sel(input logic [7:0] a, output logic [2:0] t,
                                       output logic [2:0] k);
      logic [7:0] off;
      off = a - OFS_TERM;
      t = off[7:5];
      k = off[4:2];
      if (a[1:0] != 2'h0) begin
         return SEL_NONE;
      end
      if (a >= OFS_TERM && off < 8'(N_PT) * TERM_STRIDE && k < 3'h6) begin
         return SEL_TERM;
      end
      unique case (a)
         OFS_CFG0: return SEL_CFG0;
         OFS_CFG1: return SEL_CFG1;
         OFS_MATRIX, OFS_MATRIX + 8'h04, OFS_MATRIX + 8'h08: begin
            k = 3'((a - OFS_MATRIX) >> 2);
            return SEL_MATRIX;
         end
         OFS_STATUS: return SEL_STATUS;
         OFS_SIGNATURE: return SEL_SIG;
         OFS_FUSE: return SEL_FUSE;
         default: return SEL_NONE;
      endcase
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [6:0] popcount(input logic [GBUS_W-1:0] v);
      logic [6:0] c;
      c = 7'h00;
      for (int i = 0; i < GBUS_W; i++) begin
         c = c + 7'(v[i]);
      end
      return c;
   endfunction

   logic [N_PINS-1:0] pin_drv;
   logic [N_PINS-1:0] pin_raw;
   logic [N_PINS-1:0] pin_lvl;
   logic [N_CELLS-1:0] fb_bus;
   logic [GBUS_W-1:0] mask;
   logic [GBUS_W-1:0] gbus;
   logic [LIT_W-1:0] lit;
   logic [N_PT-1:0] pt;
   logic [N_PT-1:0] ctl;
   logic [LIT_W-1:0] tm;
   logic [LIT_W-1:0] cm;
   logic casc_ok;
   logic sum;
   logic xin;
   logic comb;
   logic dval;
   logic kval;
   logic sel_clk;
   logic clk_edge;
   logic ce_block;
   logic clr;
   logic set;
   logic oe;
   logic own_pin;
   logic [31:0] rd;
   logic [31:0] cand;
   logic [2:0] rt;
   logic [2:0] rk;
   logic [2:0] wt;
   logic [2:0] wk;
   mc_sel_t rsel;
   mc_sel_t wsel;

   always_comb begin
      n = s;
      n.sync1 = pins;
      n.sync2 = s.sync1;
      // Pin levels seen by the array, with keepers on released pins
      pin_drv = {s.sync2.io_drv, s.sync2.ded_drv};
      pin_raw = {s.sync2.io, s.sync2.ded};
      if (!s.io_oe_n) begin
         pin_drv[N_DED+CELL_IDX] = 1'b1;
         pin_raw[N_DED+CELL_IDX] = s.io_out;
      end
      for (int i = 0; i < N_PINS; i++) begin
         pin_lvl[i] = pin_drv[i] ? pin_raw[i] : (s.cfg0.keeper & s.keep[i]); // RL19
         if (pin_drv[i]) begin
            n.keep[i] = pin_raw[i]; // RL19
         end
      end
      own_pin = pin_lvl[N_DED+CELL_IDX];
      fb_bus = feedback_in;
      fb_bus[CELL_IDX] = s.fb_out;
      mask = {s.matrix[2][3:0], s.matrix[1], s.matrix[0]};
      gbus = {fb_bus, pin_lvl}; // RL16
      lit = {fold_in, s.fold_out, gbus & mask}; // RL17
      for (int i = 0; i < N_PT; i++) begin
         tm = {s.term[i][2][7:0], s.term[i][1], s.term[i][0]};
         cm = {s.term[i][5][7:0], s.term[i][4], s.term[i][3]};
         // Term with no literal stays off, as an unused term should
         pt[i] = (|(tm | cm)) & (&(~tm | lit)) & (&(~cm | ~lit)); // RL1 RL18
      end
      ctl = pt & ~s.cfg0.to_sum; // RL2
      casc_ok = cascade_cells_in < CASC_MAX_CELLS;
      sum = |(pt & s.cfg0.to_sum) | (s.cfg0.cascade_en & casc_ok & cascade_in); // RL3
      unique case (s.cfg0.xor_src) // RL4
         XOR_HIGH: xin = 1'b1;
         XOR_PT: xin = ctl[s.cfg1.xor_pt];
         default: xin = 1'b0;
      endcase
      comb = sum ^ xin;
      unique case (s.cfg0.d_src) // RL5
         D_PT: dval = ctl[s.cfg1.d_pt];
         D_PIN: dval = own_pin;
         default: dval = comb;
      endcase
      kval = ctl[s.cfg1.k_pt];
      // Clock from a global pin or a term
      sel_clk = (s.cfg0.clk_sel == 2'h3) ? ctl[s.cfg1.clk_pt]
                                         : s.sync2.global_clock_pins[s.cfg0.clk_sel]; // RL8
      n.clk_prev = sel_clk;
      clk_edge = sel_clk & ~s.clk_prev; // RL9
      ce_block = s.cfg0.ce_en & (s.cfg0.clk_sel != 2'h3) & ~ctl[s.cfg1.ce_pt]; // RL10
      unique case (s.cfg0.clr_src) // RL11
         CLR_GLOBAL: clr = s.sync2.global_clear_line;
         CLR_PT: clr = ctl[s.cfg1.clr_pt];
         CLR_BOTH: clr = s.sync2.global_clear_line | ctl[s.cfg1.clr_pt];
         default: clr = 1'b0;
      endcase
      set = s.cfg0.set_en & ctl[s.cfg1.set_pt]; // RL12
      if (clr) begin
         n.ff_q = 1'b0; // RL22
      end else if (set) begin
         n.ff_q = 1'b1; // RL12
      end else if (s.cfg0.ff_mode == MODE_LATCH) begin
         if (sel_clk) begin
            n.ff_q = dval; // RL7
         end
      end else if (clk_edge && !ce_block) begin
         unique case (s.cfg0.ff_mode) // RL6
            MODE_T: n.ff_q = s.ff_q ^ dval;
            MODE_JK: n.ff_q = (dval & ~s.ff_q) | (~kval & s.ff_q);
            MODE_SR: n.ff_q = dval | (~kval & s.ff_q);
            default: n.ff_q = dval;
         endcase
      end
      unique case (s.cfg0.oe_src) // RL14
         OE_PIN0: oe = s.sync2.oe_pin[0];
         OE_PIN0_N: oe = ~s.sync2.oe_pin[0];
         OE_PIN1: oe = s.sync2.oe_pin[1];
         OE_PIN1_N: oe = ~s.sync2.oe_pin[1];
         OE_IO: oe = pin_lvl[N_DED+int'(s.cfg0.oe_idx)];
         OE_CELL: oe = oe_cell_in[s.cfg0.oe_idx];
         default: oe = 1'b0;
      endcase
      unique case (s.cfg0.io_mode) // RL15
         IO_OUT: n.io_oe_n = 1'b0;
         IO_BIDIR: n.io_oe_n = ~oe;
         default: n.io_oe_n = 1'b1;
      endcase
      n.io_out = s.cfg0.out_reg ? s.ff_q : comb; // RL13
      n.fb_out = s.cfg0.fb_reg ? s.ff_q : comb; // RL13
      n.fold_out = ~pt[s.cfg1.fold_pt]; // RL17
      n.casc_out = sum;
      n.casc_cells = (s.cfg0.cascade_en && casc_ok) ? cascade_cells_in + 4'h1 : 4'h1; // RL3

      // Register read
      rsel = reg_sel(s_axi_araddr, rt, rk);
      rd = 32'h0000_0000;
      n.rresp = RESP_OKAY;
      unique case (rsel)
         SEL_CFG0: rd = s.fuse ? 32'h0000_0000 : s.cfg0; // RL21
         SEL_CFG1: rd = s.fuse ? 32'h0000_0000 : s.cfg1;
         SEL_MATRIX: rd = s.fuse ? 32'h0000_0000 : s.matrix[rk];
         SEL_TERM: rd = s.fuse ? 32'h0000_0000 : s.term[rt][rk];
         SEL_SIG: rd = {16'h0000, s.signature}; // RL20 RL21
         SEL_FUSE: rd = {31'h0000_0000, s.fuse};
         SEL_STATUS: begin
            rd[ST_FF] = s.ff_q;
            rd[ST_SUM] = sum;
            rd[ST_COMB] = comb;
            rd[ST_PIN] = own_pin;
            rd[ST_CASC_OVF] = s.cfg0.cascade_en & ~casc_ok;
            rd[ST_FUSE] = s.fuse;
            rd[ST_PT +: N_PT] = pt;
            rd[ST_MCOUNT +: 7] = popcount(mask);
         end
         default: n.rresp = RESP_DECERR;
      endcase
      if (s.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s.arready) begin
         n.rvalid = 1'b1;
         n.rdata = rd;
      end else begin
         n.rresp = s.rresp;
      end
      n.arready = ~n.rvalid;

      // Register write, address and data in either order
      if (s_axi_awvalid && s.awready) begin
         n.aw_have = 1'b1;
         n.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wready) begin
         n.w_have = 1'b1;
         n.wdata = s_axi_wdata;
         n.wstrb = s_axi_wstrb;
      end
      if (s.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      wsel = reg_sel(s.awaddr, wt, wk);
      cand = 32'h0000_0000;
      if (s.aw_have && s.w_have && !s.bvalid) begin
         n.aw_have = 1'b0;
         n.w_have = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = RESP_OKAY;
         if (s.fuse && (wsel == SEL_CFG0 || wsel == SEL_CFG1 || wsel == SEL_MATRIX
             || wsel == SEL_TERM)) begin
            n.bresp = RESP_SLVERR; // RL21
         end else begin
            unique case (wsel)
               SEL_CFG0: n.cfg0 = merge(s.cfg0, s.wdata, s.wstrb);
               SEL_CFG1: n.cfg1 = merge(s.cfg1, s.wdata, s.wstrb);
               SEL_MATRIX: begin
                  cand = merge(s.matrix[wk], s.wdata, s.wstrb);
                  if (wk == 3'h2) begin
                     cand = cand & MATRIX_TOP_MASK;
                  end
                  n.matrix[wk] = cand;
                  // Over-full selection is refused so the matrix never picks more than forty inputs
                  if (popcount({n.matrix[2][3:0], n.matrix[1], n.matrix[0]}) >
                      7'(MATRIX_MAX)) begin
                     n.matrix = s.matrix; // RL16
                     n.bresp = RESP_SLVERR;
                  end
               end
               SEL_TERM: begin
                  cand = merge(s.term[wt][wk], s.wdata, s.wstrb);
                  n.term[wt][wk] = (wk == 3'h2 || wk == 3'h5) ? (cand & LIT_TOP_MASK) : cand;
               end
               SEL_SIG: begin
                  cand = merge({16'h0000, s.signature}, s.wdata, s.wstrb);
                  n.signature = cand[15:0]; // RL20
               end
               SEL_FUSE: n.fuse = s.fuse | (s.wstrb[0] & s.wdata[0]); // RL21
               SEL_STATUS: n.bresp = RESP_SLVERR;
               default: n.bresp = RESP_DECERR;
            endcase
         end
      end
      n.awready = ~n.aw_have & ~n.bvalid;
      n.wready = ~n.w_have & ~n.bvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.cfg0 <= CFG0_RST;
         s.cfg1 <= CFG1_RST;
         s.signature <= SIGNATURE_RST;
         s.io_oe_n <= 1'b1;
         s.fold_out <= 1'b1;
         s.casc_cells <= 4'h1;
      end else begin
         s <= n;
      end
   end

   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign io_out = s.io_out;
   assign io_oe_n = s.io_oe_n;
   assign feedback_out = s.fb_out;
   assign fold_out = s.fold_out;
   assign cascade_out = s.casc_out;
   assign cascade_cells_out = s.casc_cells;
endmodule
`default_nettype wire

// >>> mc_board.sv
// Board logic on the cell's pins: passes the bench's wanted levels through.
// Assumes our cell owns I/O pin 0; only that pin floats to a changing level when released.
`timescale 1ns/1ps
`default_nettype none
module mc_board
   import mc_pkg::*;
(
   // Clock
   input wire logic aclk,
   // Levels the board wants
   input wire mc_pins_t want,
   // Cell drive of its own pin
   input wire logic io_out,
   input wire logic io_oe_n,
   // Resolved pins
   output mc_pins_t pins
);
   logic flip = 1'b0;
   // Floating wire must not look like a held level
   always_ff @(posedge aclk) begin
      flip <= ~flip;
   end
   always_comb begin
      pins = want;
      if (!io_oe_n) begin
         pins.io[0] = io_out;
      end else if (!want.io_drv[0]) begin
         pins.io[0] = flip;
      end
   end
endmodule
`default_nettype wire

// >>> mc_cell_asserts.sv
// Checker on the cell's bus, pin and chain ports.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module mc_cell_asserts
   import mc_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Pin and chain
   input wire logic io_oe_n,
   input wire logic fold_out,
   input wire logic [3:0] cascade_cells_in,
   input wire logic [3:0] cascade_cells_out
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   chk_reset_pins: assert property ($rose(aresetn)
      |-> io_oe_n && fold_out && cascade_cells_out == 4'h1)
      else $error("pins not idle after reset");
   chk_chain_bound: assert property (cascade_cells_out <= CASC_MAX_CELLS)
      else $error("chain longer than allowed");
   chk_chain_refuse: assert property (cascade_cells_in >= 4'h8
      |=> cascade_cells_out == 4'h1)
      else $error("overlong chain accepted");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed while waiting");
   chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h30
      |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response changed while waiting");
   chk_write_answer: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
      else $error("write not answered");
   cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   cov_decerr: cover property (s_axi_rvalid && s_axi_rresp == RESP_DECERR);
   cov_chain: cover property (cascade_cells_out == 4'h8);
   cov_drive: cover property (!io_oe_n);
endmodule
bind mc_cell mc_cell_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .io_oe_n(io_oe_n),
   .fold_out(fold_out), .cascade_cells_in(cascade_cells_in), .cascade_cells_out(cascade_cells_out));
`default_nettype wire

// >>> test_mc_cell.sv
// Bench for one logic cell: a table of storage modes, then pin, chain and bus cases.
// Assumes the board model and the bound checker; term 0 watches dedicated pin 0.
`timescale 1ns/1ps
`default_nettype none
module test_mc_cell
   import mc_pkg::*;
;
   typedef struct packed {
      logic [31:0] cfg;
      logic d;
      logic gclr;
      logic [1:0] ck;
      logic [1:0] n;
      logic [2:0] st;
   } mc_row_t;
   // Rows carry state over: each expects the storage left by the one before
   // Last three: clock enable blocks, JK and SR hold with the K/R term low
   mc_row_t rows [16] = '{'{32'h1F, 1'b1, 1'b0, 2'd0, 2'd0, 3'h6},
      '{32'h1F, 1'b1, 1'b0, 2'd0, 2'd1, 3'h7},
      '{32'h3F, 1'b1, 1'b0, 2'd0, 2'd0, 3'h3}, '{32'h3F, 1'b1, 1'b0, 2'd0, 2'd1, 3'h2},
      '{32'h21F, 1'b1, 1'b0, 2'd0, 2'd1, 3'h7}, '{32'h21F, 1'b1, 1'b0, 2'd0, 2'd3, 3'h6},
      '{32'h81F, 1'b1, 1'b0, 2'd0, 2'd1, 3'h7}, '{32'h81F, 1'b0, 1'b0, 2'd0, 2'd0, 3'h1},
      '{32'h101F, 1'b0, 1'b0, 2'd0, 2'd1, 3'h1}, '{32'h101F, 1'b0, 1'b0, 2'd1, 2'd1, 3'h0},
      '{32'h1F, 1'b1, 1'b1, 2'd0, 2'd1, 3'h6}, '{32'h1801F, 1'b1, 1'b1, 2'd0, 2'd1, 3'h7},
      '{32'h1801F, 1'b0, 1'b0, 2'd0, 2'd0, 3'h1}, '{32'h401F, 1'b0, 1'b0, 2'd0, 2'd1, 3'h1},
      '{32'h41F, 1'b0, 1'b0, 2'd0, 2'd1, 3'h1}, '{32'h61F, 1'b0, 1'b0, 2'd0, 2'd1, 3'h1}};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, io_out, io_oe_n, fb_out, fold_out, casc_out;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, rd;
   logic [3:0] cc_in = 4'h0;
   logic [3:0] cc_out;
   mc_pins_t bd = '0;
   mc_pins_t pins;
   int err_count = 0;
   int n_compared = 0;
   always #5 aclk = ~aclk;
   mc_board i_board (.aclk(aclk), .want(bd), .io_out(io_out), .io_oe_n(io_oe_n), .pins(pins));
   mc_cell i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins(pins),
      .io_out(io_out), .io_oe_n(io_oe_n), .feedback_in(32'h0), .feedback_out(fb_out),
      .fold_in(3'h0), .fold_out(fold_out), .oe_cell_in(4'h0), .cascade_in(1'b0),
      .cascade_cells_in(cc_in), .cascade_out(casc_out), .cascade_cells_out(cc_out));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Readiness is sampled at the falling edge so the transfer edge is never raced
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge aclk);
         if (awready) ta = 1'b1;
         if (wready) tw = 1'b1;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (!(ta && tw));
      do begin
         @(negedge aclk);
         ta = bvalid;
         r = bresp;
         @(posedge aclk);
      end while (!ta);
      bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic g;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         g = arready;
         @(posedge aclk);
      end while (!g);
      arvalid <= 1'b0;
      do begin
         @(negedge aclk);
         g = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
      end while (!g);
      rready <= 1'b0;
   endtask
   task automatic pulse(input logic [1:0] k);
      @(posedge aclk);
      bd.global_clock_pins[k] <= 1'b1;
      repeat (3) @(posedge aclk);
      bd.global_clock_pins[k] <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask
   // Waits out the two-flop pin sync before looking
   task automatic stat(input logic [31:0] m, input logic [31:0] e);
      repeat (8) @(posedge aclk);
      axr(OFS_STATUS, rd, rs);
      chk(rd & m, e);
   endtask
   initial begin
      #100000;
      err_count++;
      finish_test;
   end
   initial begin
      bd.ded_drv = 4'hF;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      axr(OFS_CFG0, rd, rs);
      chk(rd, CFG0_RST);
      axw(OFS_MATRIX, 32'h1, rs);
      axw(OFS_TERM, 32'h1, rs);
      foreach (rows[i]) begin
         axw(OFS_CFG0, rows[i].cfg, rs);
         bd.ded[0] <= rows[i].d;
         bd.global_clear_line <= rows[i].gclr;
         repeat (4) @(posedge aclk);
         repeat (rows[i].n) pulse(rows[i].ck);
         stat(32'h7, {29'h0, rows[i].st});
      end
      axw(OFS_CFG0, 32'h0200_001F, rs);
      bd.ded[0] <= 1'b1;
      repeat (8) @(posedge aclk);
      chk({30'h0, io_oe_n, io_out}, 32'h1);
      axw(OFS_CFG0, 32'h0204_001F, rs);
      bd.ded[0] <= 1'b0;
      repeat (8) @(posedge aclk);
      chk({30'h0, io_out, fb_out}, 32'h2);
      axw(OFS_CFG0, 32'h0800_001F, rs);
      bd.io[0] <= 1'b1;
      bd.io_drv[0] <= 1'b1;
      repeat (8) @(posedge aclk);
      bd.io_drv[0] <= 1'b0;
      stat(32'h8, 32'h8);
      axw(OFS_CFG0, CFG0_RST, rs);
      stat(32'h8, 32'h0);
      axw(OFS_CFG0, 32'h1000_001F, rs);
      cc_in <= 4'h7;
      repeat (4) @(posedge aclk);
      chk({28'h0, cc_out}, 32'h8);
      cc_in <= 4'h8;
      stat(32'h10, 32'h10);
      chk({28'h0, cc_out}, 32'h1);
      axw(OFS_MATRIX, 32'hFFFF_FFFF, rs);
      axw(OFS_MATRIX + 8'h04, 32'hFF, rs);
      chk({30'h0, rs}, {30'h0, RESP_OKAY});
      stat(32'h007F_0000, 32'h0028_0000);
      axw(OFS_MATRIX + 8'h04, 32'h1FF, rs);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      axw(OFS_SIGNATURE, 32'h0000_A5C3, rs);
      axw(OFS_FUSE, 32'h1, rs);
      axw(OFS_CFG1, 32'h7, rs);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      axr(OFS_CFG0, rd, rs);
      chk(rd, 32'h0);
      axr(OFS_SIGNATURE, rd, rs);
      chk(rd, 32'h0000_A5C3);
      axr(8'h30, rd, rs);
      chk({30'h0, rs}, {30'h0, RESP_DECERR});
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      axr(OFS_CFG0, rd, rs);
      chk(rd, CFG0_RST);
      finish_test;
   end
endmodule
`default_nettype wire
